// *** hw/scr_pkg.sv ***
// Purpose: Shared constants for the synthesizer calibration register bank.
// Assumes: Byte-wide registers on a six-bit configuration address.
// Notes: Each offset, field position and reset value is named once here.
package scr_pkg;

  // Address and data widths of the configuration port.
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  // Register offsets on the configuration port.
  localparam logic [5:0] OFS_CHARGE_PUMP = 6'h23;
  localparam logic [5:0] OFS_VCO_CURRENT = 6'h24;
  localparam logic [5:0] OFS_COARSE_CAP = 6'h25;
  localparam logic [5:0] OFS_CONTROL = 6'h26;
  localparam logic [5:0] OFS_RC_OSC_HIGH = 6'h27;

  // Number of registers in the bank, used for the one-hot decode.
  localparam int NUM_REGS = 5;

  // Field positions inside the charge pump register.
  localparam int CP_CFG_MSB = 7;
  localparam int CP_CFG_LSB = 6;
  localparam int CP_EN_MSB = 5;
  localparam int CP_EN_LSB = 4;
  localparam int CP_RES_MSB = 3;
  localparam int CP_RES_LSB = 0;

  // Field positions inside the VCO current register.
  localparam int VCO_HIGH_BIT = 5;
  localparam int VCO_RES_MSB = 4;
  localparam int VCO_RES_LSB = 0;

  // Field positions inside the remaining registers.
  localparam int CAP_RES_MSB = 5;
  localparam int CAP_RES_LSB = 0;
  localparam int CTRL_MSB = 6;
  localparam int CTRL_LSB = 0;
  localparam int RC_MSB = 6;
  localparam int RC_LSB = 0;

  // Reset values of the fields.
  localparam logic [1:0] RST_CP_CFG = 2'h2;
  localparam logic [1:0] RST_CP_EN = 2'h2;
  localparam logic [3:0] RST_CP_RES = 4'h9;
  localparam logic RST_VCO_HIGH = 1'b0;
  localparam logic [4:0] RST_VCO_RES = 5'h0A;
  localparam logic [5:0] RST_CAP_RES = 6'h20;
  localparam logic [6:0] RST_CTRL = 7'h0D;
  localparam logic [6:0] RST_RC_HIGH = 7'h41;

endpackage

// *** hw/scr_cal_field.sv ***
// Purpose: One calibration result field, written by software or by the calibrator.
// Assumes: Both writers run on the same clock as the field.
// Notes: A calibration update in the same cycle as a software write wins.
`timescale 1ns/1ps
module scr_cal_field #(
  parameter int W = 4,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Software write side.
  input wire logic swWrEn,
  input wire logic [W-1:0] swData,
  // Calibration engine side.
  input wire logic hwWrEn,
  input wire logic [W-1:0] hwData,
  // Stored value.
  output logic [W-1:0] value_q
);

  // The calibrator's fresh result is newer than anything software is restoring,
  // so it takes priority when both arrive together.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      value_q <= RESET_VAL;
    end else if (hwWrEn) begin
      value_q <= hwData;
    end else if (swWrEn) begin
      value_q <= swData;
    end
  end

endmodule

// *** hw/scr_regs.sv ***
// Purpose: Synthesizer calibration register bank with result capture and readback.
// Assumes: The configuration port and calibration engine share clk_sys.
// Notes: Software may restore saved results to skip calibration on a hop.
//
// Behaviour
// - Zero charge pump enable skips that stage.
// - Low nibble holds charge pump current result.
// - Written saved results replace an earlier calibration.
// - VCO bit five selects high core; reset low.
// - VCO current result and override, reset ten.
// - Coarse capacitor setting, six bits, reset 32.
`timescale 1ns/1ps
module scr_regs
  import scr_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Configuration register port.
  input wire logic [scr_pkg::ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [scr_pkg::DATA_W-1:0] regWrData,
  input wire logic regRdEn,
  output logic [scr_pkg::DATA_W-1:0] regRdData_q,
  // Calibration engine results.
  input wire logic calDone,
  input wire logic [3:0] calCpResult,
  input wire logic [4:0] calVcoResult,
  input wire logic [5:0] calCapResult,
  // Settings toward the synthesizer.
  output logic cpCalStageEn_q,
  output logic [1:0] calConfig_q,
  output logic [1:0] chargePumpCalEnable_q,
  output logic [3:0] cpCurrentCode_q,
  output logic vcoCoreHighSelect_q,
  output logic [4:0] vcoCurrentCode_q,
  output logic [5:0] coarseCapCode_q,
  output logic [6:0] calControl_q,
  output logic [6:0] rcOscConfigHigh_q
);

  import scr_pkg::*;

  // One-hot register decode, used by both the write and the read path.
  function automatic logic [NUM_REGS-1:0] regSel(input logic [ADDR_W-1:0] addr);
    logic [NUM_REGS-1:0] sel;
    sel = '0;
    case (addr)
      OFS_CHARGE_PUMP: sel[0] = 1'b1;
      OFS_VCO_CURRENT: sel[1] = 1'b1;
      OFS_COARSE_CAP: sel[2] = 1'b1;
      OFS_CONTROL: sel[3] = 1'b1;
      OFS_RC_OSC_HIGH: sel[4] = 1'b1;
      default: sel = '0;
    endcase
    return sel;
  endfunction

  // Write strobes per register; unmapped addresses write nothing.
  logic [NUM_REGS-1:0] wrSel;
  // Read strobes per register.
  logic [NUM_REGS-1:0] rdSel;

  // Decode the address once per access direction.
  always_comb begin
    wrSel = regWrEn ? regSel(regAddr) : '0;
    rdSel = regRdEn ? regSel(regAddr) : '0;
  end

  // The charge pump current result is shared between software and calibrator.
  scr_cal_field #(
    .W(4),
    .RESET_VAL(RST_CP_RES)
  ) uCpResult (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .swWrEn(wrSel[0]),
    .swData(regWrData[CP_RES_MSB:CP_RES_LSB]),
    .hwWrEn(calDone),
    .hwData(calCpResult),
    .value_q(cpCurrentCode_q)
  );

  // The VCO current result doubles as the software override value.
  scr_cal_field #(
    .W(5),
    .RESET_VAL(RST_VCO_RES)
  ) uVcoResult (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .swWrEn(wrSel[1]),
    .swData(regWrData[VCO_RES_MSB:VCO_RES_LSB]),
    .hwWrEn(calDone),
    .hwData(calVcoResult),
    .value_q(vcoCurrentCode_q)
  );

  // The coarse capacitor array setting found by the coarse tuning stage.
  scr_cal_field #(
    .W(6),
    .RESET_VAL(RST_CAP_RES)
  ) uCapResult (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .swWrEn(wrSel[2]),
    .swData(regWrData[CAP_RES_MSB:CAP_RES_LSB]),
    .hwWrEn(calDone),
    .hwData(calCapResult),
    .value_q(coarseCapCode_q)
  );

  // Charge pump register control bits, written by software only.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      calConfig_q <= RST_CP_CFG;
      chargePumpCalEnable_q <= RST_CP_EN;
    end else if (wrSel[0]) begin
      calConfig_q <= regWrData[CP_CFG_MSB:CP_CFG_LSB];
      chargePumpCalEnable_q <= regWrData[CP_EN_MSB:CP_EN_LSB];
    end
  end

  // The stage enable is registered so the synthesizer sees a clean level;
  // it follows the enable field one cycle later.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cpCalStageEn_q <= 1'b1;
    end else begin
      cpCalStageEn_q <= (chargePumpCalEnable_q != 2'h0);
    end
  end

  // VCO core selection bit.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      vcoCoreHighSelect_q <= RST_VCO_HIGH;
    end else if (wrSel[1]) begin
      vcoCoreHighSelect_q <= regWrData[VCO_HIGH_BIT];
    end
  end

  // Calibration control and RC oscillator configuration fields.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      calControl_q <= RST_CTRL;
      rcOscConfigHigh_q <= RST_RC_HIGH;
    end else begin
      // Each field takes its own write strobe.
      if (wrSel[3]) begin
        calControl_q <= regWrData[CTRL_MSB:CTRL_LSB];
      end
      if (wrSel[4]) begin
        rcOscConfigHigh_q <= regWrData[RC_MSB:RC_LSB];
      end
    end
  end

  // Read data is registered and holds until the next read; unused bits
  // and unmapped addresses read as zero.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData_q <= 8'h00;
    end else if (regRdEn) begin
      case (1'b1)
        rdSel[0]: regRdData_q <= {calConfig_q, chargePumpCalEnable_q, cpCurrentCode_q};
        rdSel[1]: regRdData_q <= {2'h0, vcoCoreHighSelect_q, vcoCurrentCode_q};
        rdSel[2]: regRdData_q <= {2'h0, coarseCapCode_q};
        rdSel[3]: regRdData_q <= {1'b0, calControl_q};
        rdSel[4]: regRdData_q <= {1'b0, rcOscConfigHigh_q};
        default: regRdData_q <= 8'h00;
      endcase
    end
  end

  // A zero enable field written now must gate the stage two edges later,
  // provided no other write to the register follows straight after.
  chk_cp_skip_stage: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wrSel[0] && regWrData[CP_EN_MSB:CP_EN_LSB] == 2'h0) ##1 !wrSel[0]
    |=> !cpCalStageEn_q)
    else $error("Charge pump stage not skipped after zero enable.");

  // Reading the charge pump register returns the stored result nibble.
  chk_cp_readback: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rdSel[0] |=> regRdData_q[CP_RES_MSB:CP_RES_LSB] == $past(cpCurrentCode_q))
    else $error("Charge pump result readback mismatch.");

  // A restored VCO value is used as written when no calibration interferes.
  chk_restore_value: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wrSel[1] && !calDone) |=> vcoCurrentCode_q == $past(regWrData[VCO_RES_MSB:VCO_RES_LSB]))
    else $error("Restored VCO current value not applied.");

  // The core select takes bit five of the write that the previous edge accepted.
  chk_vco_core_select: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wrSel[1] ##1 !wrSel[1] |-> vcoCoreHighSelect_q == $past(regWrData[VCO_HIGH_BIT]))
    else $error("VCO core select does not follow the write.");

  // After reset release the VCO fields hold their reset values.
  chk_vco_reset_val: assert property (@(posedge clk_sys)
    $fell(sys_rst) |-> vcoCurrentCode_q == RST_VCO_RES && vcoCoreHighSelect_q == RST_VCO_HIGH)
    else $error("VCO current field not at reset value.");

  // A capacitor array restore lands in the six-bit field.
  chk_cap_restore: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wrSel[2] && !calDone) |=> coarseCapCode_q == $past(regWrData[CAP_RES_MSB:CAP_RES_LSB]))
    else $error("Coarse capacitor setting not stored.");

  // A finished calibration is visible in all three result fields.
  chk_cal_update: assert property (@(posedge clk_sys) disable iff (sys_rst)
    calDone |=> cpCurrentCode_q == $past(calCpResult)
      && vcoCurrentCode_q == $past(calVcoResult)
      && coarseCapCode_q == $past(calCapResult))
    else $error("Calibration results not captured.");

endmodule

// *** dv/scr_regs_test.sv ***
// Purpose: Self-checking bench for the synthesizer calibration register bank.
// Assumes: Strobes are driven at rising clk_sys by non-blocking assignment.
// Notes: Each scenario is its own task and judges the block before it returns.
`timescale 1ns/1ps
module scr_regs_test;
  import scr_pkg::*;
  // Stimulus; every input has a value at time zero.
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] regAddr = 6'h00;
  logic regWrEn = 1'b0;
  logic [DATA_W-1:0] regWrData = 8'h00;
  logic regRdEn = 1'b0;
  logic calDone = 1'b0;
  logic [3:0] calCpResult = 4'h0;
  logic [4:0] calVcoResult = 5'h00;
  logic [5:0] calCapResult = 6'h00;
  // Observed outputs.
  logic [DATA_W-1:0] regRdData_q;
  logic cpCalStageEn_q;
  logic [1:0] calConfig_q;
  logic [1:0] chargePumpCalEnable_q;
  logic [3:0] cpCurrentCode_q;
  logic vcoCoreHighSelect_q;
  logic [4:0] vcoCurrentCode_q;
  logic [5:0] coarseCapCode_q;
  logic [6:0] calControl_q;
  logic [6:0] rcOscConfigHigh_q;
  int failures = 0;
  int cmp_count = 0;

  scr_regs dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_q(regRdData_q), .calDone(calDone),
    .calCpResult(calCpResult), .calVcoResult(calVcoResult), .calCapResult(calCapResult),
    .cpCalStageEn_q(cpCalStageEn_q), .calConfig_q(calConfig_q),
    .chargePumpCalEnable_q(chargePumpCalEnable_q), .cpCurrentCode_q(cpCurrentCode_q),
    .vcoCoreHighSelect_q(vcoCoreHighSelect_q), .vcoCurrentCode_q(vcoCurrentCode_q),
    .coarseCapCode_q(coarseCapCode_q), .calControl_q(calControl_q),
    .rcOscConfigHigh_q(rcOscConfigHigh_q));

  // The 50 MHz system clock.
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  // Compares one value; four-state equality so an unknown never matches.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // One write; returns just after the edge that takes it, so outputs have settled.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    #1;
  endtask

  // One read; read data is registered, so it is judged after the taking edge.
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1;
    chk(regRdData_q, exp);
  endtask

  // One completed calibration with its three results.
  task automatic cal(input logic [3:0] cp, input logic [4:0] vc, input logic [5:0] cap);
    @(posedge clk_sys);
    calDone <= 1'b1;
    calCpResult <= cp;
    calVcoResult <= vc;
    calCapResult <= cap;
    @(posedge clk_sys);
    calDone <= 1'b0;
    #1;
  endtask

  // Reset values, then an unmapped place that must ignore writes and read zero.
  task automatic test_reset_unmapped();
    #1;
    chk({7'h00, cpCalStageEn_q}, 8'h01);
    rd(OFS_CHARGE_PUMP, 8'hA9);
    rd(OFS_VCO_CURRENT, 8'h0A);
    rd(OFS_COARSE_CAP, 8'h20);
    rd(OFS_CONTROL, 8'h0D);
    rd(OFS_RC_OSC_HIGH, 8'h41);
    wr(6'h28, 8'h55);
    rd(6'h28, 8'h00);
    rd(OFS_RC_OSC_HIGH, 8'h41);
  endtask

  // Every enable code; the stage enable follows one cycle after the field.
  task automatic test_charge_pump();
    for (int en = 0; en < 4; en++) begin
      wr(OFS_CHARGE_PUMP, {2'h1, en[1:0], 4'h6});
      chk({4'h0, cpCurrentCode_q}, 8'h06);
      chk({6'h00, chargePumpCalEnable_q}, {6'h00, en[1:0]});
      @(posedge clk_sys);
      #1;
      chk({7'h00, cpCalStageEn_q}, {7'h00, en != 0});
    end
    wr(OFS_CHARGE_PUMP, 8'hA5);
    chk({6'h00, calConfig_q}, 8'h02);
    rd(OFS_CHARGE_PUMP, 8'hA5);
  endtask

  // Core select, current code, coarse capacitors, control and unused bits.
  task automatic test_fields();
    wr(OFS_VCO_CURRENT, 8'h25);
    chk({7'h00, vcoCoreHighSelect_q}, 8'h01);
    chk({3'h0, vcoCurrentCode_q}, 8'h05);
    wr(OFS_VCO_CURRENT, 8'hDF);
    rd(OFS_VCO_CURRENT, 8'h1F);
    wr(OFS_COARSE_CAP, 8'hFF);
    chk({2'h0, coarseCapCode_q}, 8'h3F);
    rd(OFS_COARSE_CAP, 8'h3F);
    wr(OFS_CONTROL, 8'h07);
    chk({1'b0, calControl_q}, 8'h07);
    wr(OFS_CONTROL, 8'hFF);
    rd(OFS_CONTROL, 8'h7F);
    wr(OFS_RC_OSC_HIGH, 8'h80);
    chk({1'b0, rcOscConfigHigh_q}, 8'h00);
    rd(OFS_RC_OSC_HIGH, 8'h00);
  endtask

  // Calibration beats a same-cycle write; then saved results are restored.
  task automatic test_cal_restore();
    // Write and calibration result are taken at one and the same edge.
    @(posedge clk_sys);
    regAddr <= OFS_VCO_CURRENT;
    regWrData <= 8'h3E;
    regWrEn <= 1'b1;
    calDone <= 1'b1;
    calCpResult <= 4'h3;
    calVcoResult <= 5'h07;
    calCapResult <= 6'h11;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    calDone <= 1'b0;
    #1;
    chk({3'h0, vcoCurrentCode_q}, 8'h07);
    chk({7'h00, vcoCoreHighSelect_q}, 8'h01);
    rd(OFS_CHARGE_PUMP, 8'hA3);
    rd(OFS_COARSE_CAP, 8'h11);
    rd(OFS_VCO_CURRENT, 8'h27);
    cal(4'hF, 5'h1F, 6'h3F);
    chk({4'h0, cpCurrentCode_q}, 8'h0F);
    wr(OFS_CHARGE_PUMP, 8'hA3);
    wr(OFS_VCO_CURRENT, 8'h27);
    wr(OFS_COARSE_CAP, 8'h11);
    chk({4'h0, cpCurrentCode_q}, 8'h03);
    chk({3'h0, vcoCurrentCode_q}, 8'h07);
    chk({2'h0, coarseCapCode_q}, 8'h11);
    rd(OFS_VCO_CURRENT, 8'h27);
  endtask

  // Verdict and end of run; also reached when the watchdog fires.
  task automatic summarize();
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence: five cycles of reset, then the scenarios.
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    test_reset_unmapped();
    test_charge_pump();
    test_fields();
    test_cal_restore();
    summarize();
  end

  // The scenarios need under a hundred cycles; this bound leaves ample margin.
  initial begin
    repeat (3000) @(posedge clk_sys);
    failures++;
    summarize();
  end
endmodule
